// >>> inc/umcr_defines.svh
// Offsets, field positions and reset values of the modem line control block.
`ifndef UMCR_DEFINES_SVH
`define UMCR_DEFINES_SVH
`define UMCR_OFF_MODEM_CTRL   8'h00
`define UMCR_OFF_ENH_FEATURE  8'h04
`define UMCR_OFF_MODEM_STAT   8'h08
`define UMCR_OFF_FLOW_THRESH  8'h0c
`define UMCR_OFF_TRIG_LEVEL   8'h10
`define UMCR_MC_CLKSEL        7
`define UMCR_MC_FLOWACC       6
`define UMCR_MC_XONANY        5
`define UMCR_MC_LOOP          4
`define UMCR_MC_IRQEN         3
`define UMCR_MC_FIFORDY       2
`define UMCR_MC_RTS           1
`define UMCR_MC_DTR           0
`define UMCR_EF_ENHANCED      4
`define UMCR_EF_AUTORTS       6
`define UMCR_MC_PROT_MASK     8'he0
`define UMCR_EF_MASK          8'h50
`define UMCR_RST_MODEM_CTRL   8'h00
`define UMCR_RST_ENH_FEATURE  8'h00
`define UMCR_RST_FLOW_THRESH  8'h00
`define UMCR_RST_TRIG_LEVEL   8'h00
`define UMCR_PRESCALE_DIV4    2'h3
`endif

// >>> inc/umcr_pkg.sv
// Types shared by the modem line control block.
package umcr_pkg;
  typedef logic [7:0]  umcr_byte_t;
  typedef logic [31:0] umcr_word_t;
  typedef logic [7:0]  umcr_addr_t;
  typedef enum logic {UMCR_DIV1, UMCR_DIV4} umcr_clksel_t;
endpackage : umcr_pkg

// >>> rtl/umcr_top.sv
// Modem line control register with its APB slave, loopback and pin control.
// Overview of operation
// - Control bit 7 selects input clock divided by one (0) or four (1).
// - Control bit 6 set opens the flow threshold and trigger level registers.
// - Control bit 5 enables resume of transmission on any received character.
// - Control bit 4 loops transmit to receive and control bits into status.
// - In loopback: bit 3 to status 7, 2 to 6, 1 to 4, 0 to 5.
// - Control bit 3 clear: interrupt outputs floated, general output pin high.
// - Control bit 3 set: interrupt outputs driven, general output pin low.
// - Control bit 2 enables the combined FIFO ready register.
// - Control bit 1 drives request-to-send low when set, high when clear.
// - With automatic request-to-send on, flow control logic drives that pin instead.
// - Control bit 0 drives data-terminal-ready low when set, high when clear.
// - Bits 7 to 5 change only while the enhanced feature bit is set.
// - Modem pins are active low; status and loopback bits are active high.
//
// Added by the designer: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "umcr_defines.svh"

module umcr_top #(
  parameter int ADDR_W = 8
) (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [ADDR_W-1:0]   paddr,
  input  wire umcr_pkg::umcr_word_t pwdata,
  input  wire logic [3:0]          pstrb,
  output logic                     pready,
  output umcr_pkg::umcr_word_t     prdata,
  output logic                     pslverr,
  input  wire logic                tx_core,
  input  wire logic                rx_pin,
  output logic                     tx_pin,
  output logic                     rx_core,
  input  wire logic                cts_n,
  input  wire logic                dsr_n,
  input  wire logic                ri_n,
  input  wire logic                cd_n,
  output logic                     rts_n,
  output logic                     dtr_n,
  input  wire logic                auto_rts_assert,
  input  wire logic                irq_a_req,
  input  wire logic                irq_b_req,
  output logic                     channel_a_irq_out,
  output logic                     channel_a_irq_oe,
  output logic                     channel_b_irq_out,
  output logic                     channel_b_irq_oe,
  output logic                     general_output_pin,
  output logic                     prescale_tick,
  output logic                     flow_regs_open,
  output logic                     xon_any_en,
  output logic                     fifo_rdy_en,
  output umcr_pkg::umcr_byte_t     flow_threshold_q,
  output umcr_pkg::umcr_byte_t     trigger_level_q
);
  import umcr_pkg::*;

  umcr_byte_t   modem_line_control_r;
  umcr_byte_t   enhanced_feature_r;
  umcr_byte_t   flow_threshold_r;
  umcr_byte_t   trigger_level_r;
  logic [3:0]   modem_delta_r;
  logic [3:0]   status_hi_d_r;
  logic [1:0]   prescale_cnt_r;
  logic         prescale_tick_r;
  umcr_word_t   prdata_r;
  logic         pslverr_r;
  logic [3:0]   status_hi;
  logic [3:0]   delta_set;
  logic         setup_ph;
  logic         access_ph;
  logic         wr_en;
  logic         lane0;
  umcr_clksel_t clk_sel;

  // Decodes an address into a hit on one of the mapped registers.
  function automatic logic addr_is(input logic [ADDR_W-1:0] a, input umcr_addr_t off);
    addr_is = (a == ADDR_W'(off));
  endfunction : addr_is

  // Merges protected and open bits of a control write.
  function automatic umcr_byte_t mc_merge(input umcr_byte_t old_v, input umcr_byte_t new_v,
                                          input logic enh);
    umcr_byte_t keep;
    keep     = enh ? 8'h00 : `UMCR_MC_PROT_MASK;
    mc_merge = (old_v & keep) | (new_v & ~keep);
  endfunction : mc_merge

  assign setup_ph  = psel && !penable;
  assign access_ph = psel && penable;
  assign lane0     = pstrb[0];
  assign wr_en     = access_ph && pwrite && lane0;

  // The slave answers in the first access cycle, so there are no wait states.
  assign pready  = access_ph;
  assign prdata  = prdata_r;
  assign pslverr = pslverr_r && access_ph;

  // Control register: protected upper bits obey the enhanced feature bit.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      modem_line_control_r <= `UMCR_RST_MODEM_CTRL;
    end else if (wr_en && addr_is(paddr, `UMCR_OFF_MODEM_CTRL)) begin
      modem_line_control_r <= mc_merge(modem_line_control_r, pwdata[7:0],
                                       enhanced_feature_r[`UMCR_EF_ENHANCED]);
    end
  end

  // Only the enhanced enable and automatic request-to-send bits are kept here.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enhanced_feature_r <= `UMCR_RST_ENH_FEATURE;
    end else if (wr_en && addr_is(paddr, `UMCR_OFF_ENH_FEATURE)) begin
      enhanced_feature_r <= pwdata[7:0] & `UMCR_EF_MASK;
    end
  end

  // Threshold and trigger registers are reachable only while the access bit is set.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flow_threshold_r <= `UMCR_RST_FLOW_THRESH;
      trigger_level_r  <= `UMCR_RST_TRIG_LEVEL;
    end else if (wr_en && modem_line_control_r[`UMCR_MC_FLOWACC]) begin
      if (addr_is(paddr, `UMCR_OFF_FLOW_THRESH)) begin
        flow_threshold_r <= pwdata[7:0];
      end
      if (addr_is(paddr, `UMCR_OFF_TRIG_LEVEL)) begin
        trigger_level_r <= pwdata[7:0];
      end
    end
  end

  // Status bits are active high; the pins are inverted outside loopback.
  always_comb begin
    if (modem_line_control_r[`UMCR_MC_LOOP]) begin
      status_hi[3] = modem_line_control_r[`UMCR_MC_IRQEN];
      status_hi[2] = modem_line_control_r[`UMCR_MC_FIFORDY];
      status_hi[1] = modem_line_control_r[`UMCR_MC_DTR];
      status_hi[0] = modem_line_control_r[`UMCR_MC_RTS];
    end else begin
      status_hi = {~cd_n, ~ri_n, ~dsr_n, ~cts_n};
    end
  end

  // Ring indicator flags only the end of a ring; the others flag any change.
  assign delta_set = {status_hi[3] ^ status_hi_d_r[3],
                      status_hi_d_r[2] & ~status_hi[2],
                      status_hi[1] ^ status_hi_d_r[1],
                      status_hi[0] ^ status_hi_d_r[0]};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_hi_d_r <= 4'h0;
    end else begin
      status_hi_d_r <= status_hi;
    end
  end

  // Only the flags that went out in the read data are cleared, and a new
  // change in the same cycle wins over the clear.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      modem_delta_r <= 4'h0;
    end else if (access_ph && !pwrite && addr_is(paddr, `UMCR_OFF_MODEM_STAT)) begin
      modem_delta_r <= (modem_delta_r & ~prdata_r[3:0]) | delta_set;
    end else begin
      modem_delta_r <= modem_delta_r | delta_set;
    end
  end

  // Read data and the error answer are prepared in the setup cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r  <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else if (setup_ph) begin
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
      if (addr_is(paddr, `UMCR_OFF_MODEM_CTRL)) begin
        prdata_r[7:0] <= modem_line_control_r;
      end else if (addr_is(paddr, `UMCR_OFF_ENH_FEATURE)) begin
        prdata_r[7:0] <= enhanced_feature_r;
      end else if (addr_is(paddr, `UMCR_OFF_MODEM_STAT)) begin
        prdata_r[7:0] <= {status_hi, modem_delta_r};
      end else if (addr_is(paddr, `UMCR_OFF_FLOW_THRESH)) begin
        prdata_r[7:0] <= modem_line_control_r[`UMCR_MC_FLOWACC] ?
                         flow_threshold_r : 8'h00;
      end else if (addr_is(paddr, `UMCR_OFF_TRIG_LEVEL)) begin
        prdata_r[7:0] <= modem_line_control_r[`UMCR_MC_FLOWACC] ?
                         trigger_level_r : 8'h00;
      end else begin
        pslverr_r <= 1'b1;
      end
    end
  end

  // Prescaler: a tick on every clock, or on every fourth clock.
  assign clk_sel = modem_line_control_r[`UMCR_MC_CLKSEL] ? UMCR_DIV4 : UMCR_DIV1;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prescale_cnt_r  <= 2'h0;
      prescale_tick_r <= 1'b0;
    end else begin
      unique case (clk_sel)
        UMCR_DIV1: begin
          prescale_cnt_r  <= 2'h0;
          prescale_tick_r <= 1'b1;
        end
        UMCR_DIV4: begin
          prescale_cnt_r  <= prescale_cnt_r + 2'h1;
          prescale_tick_r <= (prescale_cnt_r == `UMCR_PRESCALE_DIV4);
        end
      endcase
    end
  end

  assign prescale_tick = prescale_tick_r;

  // Loopback holds the line idle so nothing leaks onto the far end.
  assign rx_core = modem_line_control_r[`UMCR_MC_LOOP] ? tx_core : rx_pin;
  assign tx_pin  = modem_line_control_r[`UMCR_MC_LOOP] ? 1'b1 : tx_core;

  assign rts_n = enhanced_feature_r[`UMCR_EF_AUTORTS] ? ~auto_rts_assert
                                                      : ~modem_line_control_r[`UMCR_MC_RTS];
  assign dtr_n = ~modem_line_control_r[`UMCR_MC_DTR];

  assign channel_a_irq_oe   = modem_line_control_r[`UMCR_MC_IRQEN];
  assign channel_b_irq_oe   = modem_line_control_r[`UMCR_MC_IRQEN];
  assign channel_a_irq_out  = irq_a_req;
  assign channel_b_irq_out  = irq_b_req;
  assign general_output_pin = ~modem_line_control_r[`UMCR_MC_IRQEN];

  assign flow_regs_open   = modem_line_control_r[`UMCR_MC_FLOWACC];
  assign xon_any_en       = modem_line_control_r[`UMCR_MC_XONANY];
  assign fifo_rdy_en      = modem_line_control_r[`UMCR_MC_FIFORDY];
  assign flow_threshold_q = flow_threshold_r;
  assign trigger_level_q  = trigger_level_r;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_ctrl_write;
    wr_en && addr_is(paddr, `UMCR_OFF_MODEM_CTRL);
  endsequence

  sequence s_prot_write;
    s_ctrl_write ##0 !enhanced_feature_r[`UMCR_EF_ENHANCED];
  endsequence

  // The reset edge itself is left out, since the tick flop is still held clear there.
  a_div1_tick_each: assert property (
    presetn && !modem_line_control_r[`UMCR_MC_CLKSEL] |=> prescale_tick)
    else $error("Divide-by-one prescale missed a tick.");

  // The three quiet cycles are looked back on from the end of the divide-by-four run.
  a_div4_tick_gap: assert property (
    modem_line_control_r[`UMCR_MC_CLKSEL] && prescale_tick ##1
    modem_line_control_r[`UMCR_MC_CLKSEL] [*3]
    |-> !prescale_tick && !$past(prescale_tick) && !$past(prescale_tick, 2) ##1 prescale_tick)
    else $error("Divide-by-four prescale tick spacing is wrong.");

  a_flow_gate_write: assert property (
    wr_en && addr_is(paddr, `UMCR_OFF_FLOW_THRESH) &&
    !modem_line_control_r[`UMCR_MC_FLOWACC] |=> $stable(flow_threshold_r))
    else $error("Threshold register written while closed.");

  a_trig_gate_write: assert property (
    wr_en && addr_is(paddr, `UMCR_OFF_TRIG_LEVEL) &&
    !modem_line_control_r[`UMCR_MC_FLOWACC] |=> $stable(trigger_level_r))
    else $error("Trigger level register written while closed.");

  a_flow_open_write: assert property (
    wr_en && addr_is(paddr, `UMCR_OFF_FLOW_THRESH) &&
    modem_line_control_r[`UMCR_MC_FLOWACC] |=> flow_threshold_r == $past(pwdata[7:0]))
    else $error("Threshold register missed a write while open.");

  a_xon_any_out: assert property (
    s_ctrl_write ##0 enhanced_feature_r[`UMCR_EF_ENHANCED]
    |=> xon_any_en == $past(pwdata[`UMCR_MC_XONANY]))
    else $error("Resume-on-any enable does not follow the write.");

  a_clksel_write: assert property (
    s_ctrl_write ##0 enhanced_feature_r[`UMCR_EF_ENHANCED]
    |=> modem_line_control_r[`UMCR_MC_CLKSEL] == $past(pwdata[`UMCR_MC_CLKSEL]))
    else $error("Clock select does not follow the write.");

  a_loop_rx_path: assert property (
    modem_line_control_r[`UMCR_MC_LOOP] |-> rx_core == tx_core && tx_pin)
    else $error("Loopback data path is wrong.");

  a_loop_status_map: assert property (
    modem_line_control_r[`UMCR_MC_LOOP] |->
    status_hi == {modem_line_control_r[3], modem_line_control_r[2],
                  modem_line_control_r[0], modem_line_control_r[1]})
    else $error("Loopback status mapping is wrong.");

  a_irq_float_op: assert property (
    !modem_line_control_r[`UMCR_MC_IRQEN] |->
    !channel_a_irq_oe && !channel_b_irq_oe && general_output_pin)
    else $error("Interrupt outputs not floated with general output high.");

  a_irq_drive_op: assert property (
    modem_line_control_r[`UMCR_MC_IRQEN] |->
    channel_a_irq_oe && channel_b_irq_oe && !general_output_pin)
    else $error("Interrupt outputs not driven with general output low.");

  a_fifo_rdy_en: assert property (
    s_ctrl_write |=> fifo_rdy_en == $past(pwdata[`UMCR_MC_FIFORDY]))
    else $error("FIFO ready enable does not follow the write.");

  a_rts_manual: assert property (
    s_ctrl_write ##0 !enhanced_feature_r[`UMCR_EF_AUTORTS]
    |=> rts_n == !$past(pwdata[`UMCR_MC_RTS]) || enhanced_feature_r[`UMCR_EF_AUTORTS])
    else $error("Request-to-send pin does not follow the control bit.");

  a_rts_auto: assert property (
    enhanced_feature_r[`UMCR_EF_AUTORTS] |-> rts_n == !auto_rts_assert)
    else $error("Request-to-send pin ignores flow control.");

  a_dtr_manual: assert property (
    s_ctrl_write |=> dtr_n == !$past(pwdata[`UMCR_MC_DTR]))
    else $error("Data-terminal-ready pin does not follow the write.");

  a_prot_bits_hold: assert property (
    s_prot_write |=> modem_line_control_r[7:5] == $past(modem_line_control_r[7:5]))
    else $error("Protected control bits changed without the enhanced bit.");

  a_status_pin_pol: assert property (
    !modem_line_control_r[`UMCR_MC_LOOP] |-> status_hi == ~{cd_n, ri_n, dsr_n, cts_n})
    else $error("Status bits do not invert the modem pins.");

  a_reset_clear: assert property (
    $rose(presetn) |-> modem_line_control_r == 8'h00)
    else $error("Control register not cleared by reset.");

endmodule : umcr_top
`default_nettype wire

// >>> tb/umcr_modem.sv
// Behavioural modem that drives the control input pins of the block.
`timescale 1ns/1ns
`default_nettype none
module umcr_modem (
  input  wire logic [3:0] lines,
  input  wire logic       rx_bit,
  output logic            cd_n,
  output logic            ri_n,
  output logic            dsr_n,
  output logic            cts_n,
  output logic            rx_pin
);
  // Lines holds the asserted states, so every pin is the inverse.
  assign cd_n   = ~lines[3];
  assign ri_n   = ~lines[2];
  assign dsr_n  = ~lines[1];
  assign cts_n  = ~lines[0];
  // The serial line follows the bench, so a receive path stuck at mark shows up.
  assign rx_pin = rx_bit;
endmodule : umcr_modem
`default_nettype wire

// >>> tb/uart_modem_control_register_tb.sv
// Self-checking bench for the modem line control register block.
`timescale 1ns/1ns
`default_nettype none
`include "umcr_defines.svh"
module uart_modem_control_register_tb;
  import umcr_pkg::*;
  logic       pclk, presetn, psel, penable, pwrite, tx_core, auto_rts_assert;
  logic       irq_a_req, irq_b_req, pready, pslverr, tx_pin, rx_core, rx_pin;
  logic       cts_n, dsr_n, ri_n, cd_n, rts_n, dtr_n, a_out, a_oe, b_out, b_oe;
  logic       gpo, tick, fro, xae, fre, err, rx_bit;
  logic [7:0] paddr;
  logic [3:0] pstrb, lines;
  umcr_word_t pwdata, prdata, rd, v, seed, cnt;
  umcr_byte_t thr_q, tlv_q;
  int         num_errors, n_tests, modem_line_control, enh, thr, tlv;

  umcr_modem modem (.lines(lines), .rx_bit(rx_bit), .cd_n(cd_n), .ri_n(ri_n), .dsr_n(dsr_n),
    .cts_n(cts_n), .rx_pin(rx_pin));

  umcr_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .tx_core(tx_core), .rx_pin(rx_pin),
    .tx_pin(tx_pin), .rx_core(rx_core), .cts_n(cts_n), .dsr_n(dsr_n), .ri_n(ri_n),
    .cd_n(cd_n), .rts_n(rts_n), .dtr_n(dtr_n), .auto_rts_assert(auto_rts_assert),
    .irq_a_req(irq_a_req), .irq_b_req(irq_b_req), .channel_a_irq_out(a_out),
    .channel_a_irq_oe(a_oe), .channel_b_irq_out(b_out), .channel_b_irq_oe(b_oe),
    .general_output_pin(gpo), .prescale_tick(tick), .flow_regs_open(fro),
    .xon_any_en(xae), .fifo_rdy_en(fre), .flow_threshold_q(thr_q),
    .trigger_level_q(tlv_q));

  function automatic umcr_word_t rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic end_of_test();
    $display("comparisons=%0d mismatches=%0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_of_test

  // The request is held until pready is seen high; after 16 cycles without it the run ends as failed.
  task automatic apb(input logic w, input logic [7:0] a, input umcr_word_t d);
    int i;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 16) begin
      num_errors++;
      end_of_test();
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wreg(input logic [7:0] a, input umcr_word_t d);
    apb(1'b1, a, d);
    if (pstrb[0]) begin
      if (a == `UMCR_OFF_MODEM_CTRL) modem_line_control = enh[4] ? d[7:0] : {modem_line_control[7:5], d[4:0]};
      if (a == `UMCR_OFF_ENH_FEATURE) enh = d & 32'h50;
      if (a == `UMCR_OFF_FLOW_THRESH && modem_line_control[6]) thr = d[7:0];
      if (a == `UMCR_OFF_TRIG_LEVEL && modem_line_control[6]) tlv = d[7:0];
    end
  endtask : wreg

  task automatic check_outs();
    @(negedge pclk);
    chk(rts_n, enh[6] ? !auto_rts_assert : !modem_line_control[1]);
    chk(dtr_n, !modem_line_control[0]);
    chk({a_oe, b_oe, gpo}, modem_line_control[3] ? 3'h6 : 3'h1);
    if (modem_line_control[3]) chk({a_out, b_out}, {irq_a_req, irq_b_req});
    chk({fro, xae, fre}, {modem_line_control[6], modem_line_control[5], modem_line_control[2]});
    chk({tx_pin, rx_core}, modem_line_control[4] ? {1'b1, tx_core} : {tx_core, rx_pin});
    chk(thr_q, thr);
    chk(tlv_q, tlv);
    apb(1'b0, `UMCR_OFF_MODEM_CTRL, 32'h0);
    chk(rd, modem_line_control);
    chk(err, 1'b0);
    apb(1'b0, `UMCR_OFF_MODEM_STAT, 32'h0);
    chk(rd[7:4], modem_line_control[4] ? {modem_line_control[3], modem_line_control[2], modem_line_control[0], modem_line_control[1]} : lines);
    apb(1'b0, `UMCR_OFF_FLOW_THRESH, 32'h0);
    chk(rd, modem_line_control[6] ? thr : 0);
    apb(1'b0, `UMCR_OFF_TRIG_LEVEL, 32'h0);
    chk(rd, modem_line_control[6] ? tlv : 0);
    cnt = 0;
    repeat (8) begin
      @(negedge pclk);
      cnt += tick;
    end
    chk(cnt, modem_line_control[7] ? 2 : 8);
  endtask : check_outs

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  // A lost clock ends the run here; a hung handshake is ended by apb after 16 cycles.
  initial begin
    #2000000;
    num_errors++;
    end_of_test();
  end

  initial begin
    seed = 32'h6898;
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    pstrb = 4'hf;
    {tx_core, auto_rts_assert, irq_a_req, irq_b_req, lines, rx_bit} = '0;
    {modem_line_control, enh, thr, tlv, num_errors, n_tests} = '0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    check_outs();
    wreg(`UMCR_OFF_MODEM_CTRL, 32'hff);
    check_outs();
    apb(1'b0, 8'h20, 32'h0);
    chk(err, 1'b1);
    // A write with no byte strobe must leave the register alone.
    pstrb <= 4'h0;
    wreg(`UMCR_OFF_MODEM_CTRL, 32'h0);
    pstrb <= 4'hf;
    check_outs();
    repeat (48) begin
      v = rnd();
      @(posedge pclk);
      rx_bit          <= v[7];
      tx_core         <= v[8];
      auto_rts_assert <= v[9];
      irq_a_req       <= v[10];
      irq_b_req       <= v[11];
      lines           <= v[15:12];
      wreg(`UMCR_OFF_ENH_FEATURE, {24'h0, v[23:16]});
      wreg(`UMCR_OFF_MODEM_CTRL, {24'h0, v[31:24]});
      wreg(`UMCR_OFF_FLOW_THRESH, rnd());
      wreg(`UMCR_OFF_TRIG_LEVEL, rnd());
      check_outs();
    end
    // A reset in mid-run must bring every register back to its cleared state.
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    {modem_line_control, enh, thr, tlv} = '0;
    check_outs();
    end_of_test();
  end
endmodule : uart_modem_control_register_tb
`default_nettype wire
